/* File: rtl/dtc_pkg.sv */
// Constants and types shared by the dual timer/counter block
package dtc_pkg;

  // ---------------------------------------------------------------
  // Special-function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h88; // timer_control_register
  localparam logic [7:0] ADDR_MODE  = 8'h89; // timer_mode_register
  localparam logic [7:0] ADDR_T0_LO = 8'h8A; // timer0_count_low
  localparam logic [7:0] ADDR_T1_LO = 8'h8B; // timer1_count_low
  localparam logic [7:0] ADDR_T0_HI = 8'h8C; // timer0_count_high
  localparam logic [7:0] ADDR_T1_HI = 8'h8D; // timer1_count_high

  // ---------------------------------------------------------------
  // Control register bit positions
  // ---------------------------------------------------------------
  localparam int CTRL_RUN0  = 4; // run_bit_t0
  localparam int CTRL_FLAG0 = 5; // overflow_flag_t0
  localparam int CTRL_RUN1  = 6; // run_bit_t1
  localparam int CTRL_FLAG1 = 7; // overflow_flag_t1

  // ---------------------------------------------------------------
  // Mode register field positions
  // ---------------------------------------------------------------
  localparam int MODE0_LSB = 0; // Timer 0 mode field [1:0]
  localparam int SRC0      = 2; // source_select_t0
  localparam int QUAL0     = 3; // pin_qualify_t0
  localparam int MODE1_LSB = 4; // Timer 1 mode field [5:4]
  localparam int SRC1      = 6; // source_select_t1
  localparam int QUAL1     = 7; // pin_qualify_t1

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00; // Every register

  // ---------------------------------------------------------------
  // Timer operating modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DTC_MODE_13     = 2'h0, // 13-bit count
    DTC_MODE_16     = 2'h1, // 16-bit count
    DTC_MODE_RELOAD = 2'h2, // 8-bit with autoreload
    DTC_MODE_SPLIT  = 2'h3  // Split / hold
  } dtc_mode_e;

endpackage

/* File: rtl/dtc_pin_sync.sv */
// Pin synchroniser with falling-edge detector for the timer inputs
`timescale 1ns/1ps
module dtc_pin_sync #(
  parameter int W = 4 // Number of pins
) (
  // Clock, reset, enable
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_ce,
  // Asynchronous pins
  input  wire logic [W-1:0] i_pin,
  // Synchronised results
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_fall
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [W-1:0] meta_q;   // First stage, read by stage two only
  logic [W-1:0] sync_q;   // Second stage, safe level
  logic [W-1:0] prev_q;   // Delayed level for edge detection
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;
  logic [W-1:0] prev_d;

  // Next values: a plain shift chain
  always_comb begin
    meta_d = i_pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // Pins idle high, so reset to ones avoids a false edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else if (i_ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Outputs never look at the first stage
  assign o_level = sync_q;
  assign o_fall  = prev_q & ~sync_q;

endmodule

/* File: rtl/dtc_timers.sv */
// Dual 8/13/16-bit timer/counter with special-function registers
`timescale 1ns/1ps
//
// Function
// R01 - 13-bit mode: high byte plus low five bits
// R02 - Wrap to zero sets overflow flag
// R03 - Count when run and (no qualify or pin)
// R04 - Qualify bits at mode bits 3, 7
// R05 - Timer 0 run bit at control bit 4
// R06 - Run bit change keeps count registers
// R07 - 16-bit mode uses all sixteen bits
// R08 - Autoreload: low overflows, flag, copy high
// R09 - Autoreload leaves high byte unchanged
// R10 - Timer 1 split mode freezes count
// R11 - Split: Timer 0 low uses Timer 0 controls
// R12 - Split: Timer 0 high uses Timer 1 run/flag
// R13 - Timer 1 stop/start via split; baud tick
// R14 - No prescaler: one tick per clock
// R15 - Count bytes mapped, reset to zero
// R16 - Flag cleared when core vectors to handler
// R17 - Timer 1 run bit at control bit 6
// R18 - Source select: clock or pin falling edge
// R19 - Two-bit mode field per timer
module dtc_timers (
  // Clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_ce,
  // Special-function register port of the core
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  // Interrupt vector acknowledges from the core
  input  wire logic       i_vector_t0,
  input  wire logic       i_vector_t1,
  // External pins
  input  wire logic       i_count_pin_t0,
  input  wire logic       i_count_pin_t1,
  input  wire logic       i_ext_irq_pin_zero,
  input  wire logic       i_ext_irq_pin_one,
  // Requests and baud tick
  output logic            o_irq_t0,
  output logic            o_irq_t1,
  output logic            o_baud_tick_t1
);

  // ---------------------------------------------------------------
  // Counting step for one timer
  // ---------------------------------------------------------------
  // Returns {overflow, high, low} after one advance
  function automatic logic [16:0] dtc_step(input logic [1:0] mode,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [5:0]  l6;
    logic [8:0]  l9;
    logic [8:0]  h9;
    logic [16:0] w17;
    begin
      l6  = {1'b0, lo[4:0]} + 6'h01;
      l9  = {1'b0, lo} + 9'h001;
      h9  = {1'b0, hi} + {8'h00, l6[5]};
      w17 = {1'b0, hi, lo} + 17'h00001;
      case (mode)
        dtc_pkg::DTC_MODE_13: begin
          // Upper three low bits take no part in the count
          dtc_step = {h9[8], h9[7:0], lo[7:5], l6[4:0]}; // R01
        end
        dtc_pkg::DTC_MODE_16: dtc_step = w17; // R07
        dtc_pkg::DTC_MODE_RELOAD: begin
          // High byte is the reload value and never moves
          dtc_step = {l9[8], hi, l9[8] ? hi : l9[7:0]}; // R08 R09
        end
        default: begin
          // Split: only the low byte counts here
          dtc_step = {l9[8], hi, l9[7:0]}; // R11
        end
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] t0_lo_q, t0_lo_d;       // timer0_count_low
  logic [7:0] t0_hi_q, t0_hi_d;       // timer0_count_high
  logic [7:0] t1_lo_q, t1_lo_d;       // timer1_count_low
  logic [7:0] t1_hi_q, t1_hi_d;       // timer1_count_high
  logic [7:0] mode_q, mode_d;         // timer_mode_register
  logic       run0_q, run0_d;         // run_bit_t0
  logic       run1_q, run1_d;         // run_bit_t1
  logic       flag0_q, flag0_d;       // overflow_flag_t0
  logic       flag1_q, flag1_d;       // overflow_flag_t1
  logic [7:0] rdata_q, rdata_d;       // Registered read data
  logic       baud_q, baud_d;         // Timer 1 overflow tick

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_level;              // Synchronised levels
  logic [3:0] pin_fall;               // Falling-edge pulses

  dtc_pin_sync #(
    .W (4)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_pin    ({i_ext_irq_pin_one, i_ext_irq_pin_zero,
                i_count_pin_t1, i_count_pin_t0}),
    .o_level  (pin_level),
    .o_fall   (pin_fall)
  );

  // ---------------------------------------------------------------
  // Mode decode and count enables
  // ---------------------------------------------------------------
  logic [1:0]  mode0;                 // Timer 0 mode field
  logic [1:0]  mode1;                 // Timer 1 mode field
  logic        pin_qualify_t0;                 // Timer 0 run and qualified
  logic        pin_qualify_t1;                 // Timer 1 run and qualified
  logic        tick0;                 // Timer 0 source event
  logic        tick1;                 // Timer 1 source event
  logic        inc0;                  // Timer 0 advances now
  logic        inc1;                  // Timer 1 advances now
  logic [16:0] step0;                 // Timer 0 next count
  logic [16:0] step1;                 // Timer 1 next count
  logic [8:0]  hsplit;                // Split high byte plus one
  logic        split0;                // Timer 0 in split mode
  logic        inc_hs;                // Split high byte advances
  logic        set0;                  // Event for flag 0
  logic        set1;                  // Event for flag 1
  logic        ovf1;                  // Timer 1 own overflow

  assign mode0  = mode_q[dtc_pkg::MODE0_LSB +: 2]; // R19
  assign mode1  = mode_q[dtc_pkg::MODE1_LSB +: 2]; // R19
  assign split0 = (mode0 == dtc_pkg::DTC_MODE_SPLIT);

  // Qualify bit lets the irq pin level gate a pulse width count
  assign pin_qualify_t0 = run0_q &
                 (!mode_q[dtc_pkg::QUAL0] | pin_level[2]); // R03 R04
  assign pin_qualify_t1 = run1_q &
                 (!mode_q[dtc_pkg::QUAL1] | pin_level[3]); // R03 R04

  // No divide-by-twelve: the timer function ticks every clock
  assign tick0 = mode_q[dtc_pkg::SRC0] ? pin_fall[0] : 1'b1; // R14 R18
  assign tick1 = mode_q[dtc_pkg::SRC1] ? pin_fall[1] : 1'b1; // R14 R18

  // Timer 1 in its split mode simply holds, as if stopped
  assign inc0 = pin_qualify_t0 & tick0; // R11
  assign inc1 = pin_qualify_t1 & tick1 &
                (mode1 != dtc_pkg::DTC_MODE_SPLIT); // R10 R13

  assign step0 = dtc_step(mode0, t0_hi_q, t0_lo_q);
  assign step1 = dtc_step(mode1, t1_hi_q, t1_lo_q);

  // Split high byte counts clocks under the Timer 1 run bit only
  assign hsplit = {1'b0, t0_hi_q} + 9'h001;
  assign inc_hs = split0 & run1_q; // R12

  assign set0 = inc0 & step0[16]; // R02
  assign ovf1 = inc1 & step1[16];
  // Timer 1 loses its flag to the split high byte
  assign set1 = split0 ? (inc_hs & hsplit[8]) : ovf1; // R02 R12

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Software writes to a byte win over a count in the same cycle
  always_comb begin
    t0_lo_d = t0_lo_q;
    t0_hi_d = t0_hi_q;
    t1_lo_d = t1_lo_q;
    t1_hi_d = t1_hi_q;
    mode_d  = mode_q;
    run0_d  = run0_q;
    run1_d  = run1_q;
    flag0_d = flag0_q;
    flag1_d = flag1_q;
    baud_d  = ovf1; // R13
    // Timer 0 count
    if (inc0) begin
      t0_lo_d = step0[7:0];
      if (!split0) begin
        t0_hi_d = step0[15:8];
      end
    end
    if (inc_hs) begin
      t0_hi_d = hsplit[7:0]; // R12
    end
    // Timer 1 count
    if (inc1) begin
      t1_lo_d = step1[7:0];
      t1_hi_d = step1[15:8];
    end
    // Acknowledge clears come first
    if (i_vector_t0) begin
      flag0_d = 1'b0; // R16
    end
    if (i_vector_t1) begin
      flag1_d = 1'b0; // R16
    end
    // Register writes; run bits only steer, never clear counts
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        dtc_pkg::ADDR_CTRL: begin
          run0_d  = i_sfr_wdata[dtc_pkg::CTRL_RUN0];  // R05 R06
          run1_d  = i_sfr_wdata[dtc_pkg::CTRL_RUN1];  // R17 R06
          flag0_d = i_sfr_wdata[dtc_pkg::CTRL_FLAG0];
          flag1_d = i_sfr_wdata[dtc_pkg::CTRL_FLAG1];
        end
        dtc_pkg::ADDR_MODE:  mode_d  = i_sfr_wdata; // R04 R19
        dtc_pkg::ADDR_T0_LO: t0_lo_d = i_sfr_wdata; // R15
        dtc_pkg::ADDR_T1_LO: t1_lo_d = i_sfr_wdata; // R15
        dtc_pkg::ADDR_T0_HI: t0_hi_d = i_sfr_wdata; // R15
        dtc_pkg::ADDR_T1_HI: t1_hi_d = i_sfr_wdata; // R15
        default: begin
          // Other addresses belong to other blocks
        end
      endcase
    end
    // An overflow in the clearing cycle is never lost
    if (set0) begin
      flag0_d = 1'b1; // R02
    end
    if (set1) begin
      flag1_d = 1'b1; // R02 R12
    end
    // Read mux; unowned control bits read as zero
    case (i_sfr_addr)
      dtc_pkg::ADDR_CTRL:  rdata_d = {flag1_q, run1_q, flag0_q,
                                      run0_q, 4'h0};
      dtc_pkg::ADDR_MODE:  rdata_d = mode_q;
      dtc_pkg::ADDR_T0_LO: rdata_d = t0_lo_q;
      dtc_pkg::ADDR_T1_LO: rdata_d = t1_lo_q;
      dtc_pkg::ADDR_T0_HI: rdata_d = t0_hi_q;
      dtc_pkg::ADDR_T1_HI: rdata_d = t1_hi_q;
      default:             rdata_d = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  // Clock enable low freezes every bit of state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      t0_lo_q <= dtc_pkg::RST_BYTE; // R15
      t0_hi_q <= dtc_pkg::RST_BYTE;
      t1_lo_q <= dtc_pkg::RST_BYTE;
      t1_hi_q <= dtc_pkg::RST_BYTE;
      mode_q  <= dtc_pkg::RST_BYTE;
      run0_q  <= 1'b0;
      run1_q  <= 1'b0;
      flag0_q <= 1'b0;
      flag1_q <= 1'b0;
      rdata_q <= dtc_pkg::RST_BYTE;
      baud_q  <= 1'b0;
    end else if (i_ce) begin
      t0_lo_q <= t0_lo_d;
      t0_hi_q <= t0_hi_d;
      t1_lo_q <= t1_lo_d;
      t1_hi_q <= t1_hi_d;
      mode_q  <= mode_d;
      run0_q  <= run0_d;
      run1_q  <= run1_d;
      flag0_q <= flag0_d;
      flag1_q <= flag1_d;
      rdata_q <= rdata_d;
      baud_q  <= baud_d;
    end
  end

  // Outputs straight from flops
  assign o_sfr_rdata    = rdata_q;
  assign o_irq_t0       = flag0_q;
  assign o_irq_t1       = flag1_q;
  assign o_baud_tick_t1 = baud_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_run_off_hold: assert property (@(posedge i_clk) // R06
    disable iff (!i_arst_n)
    i_ce && !run0_q && !i_sfr_wr |=> $stable(t0_lo_q))
    else $error("timer 0 low moved while stopped");
  a_gate_pin_low: assert property (@(posedge i_clk) // R03
    disable iff (!i_arst_n)
    i_ce && mode_q[dtc_pkg::QUAL0] && !pin_level[2] && !i_sfr_wr
    |=> $stable(t0_lo_q))
    else $error("timer 0 counted with qualify pin low");
  a_clock_tick: assert property (@(posedge i_clk) // R14
    disable iff (!i_arst_n)
    i_ce && pin_qualify_t0 && !mode_q[dtc_pkg::SRC0] &&
    mode0 == dtc_pkg::DTC_MODE_16 && !i_sfr_wr
    |=> {t0_hi_q, t0_lo_q} == $past({t0_hi_q, t0_lo_q}) + 16'h0001)
    else $error("16-bit timer did not advance by one");
  a_mode13_carry: assert property (@(posedge i_clk) // R01
    disable iff (!i_arst_n)
    i_ce && inc0 && mode0 == dtc_pkg::DTC_MODE_13 &&
    t0_lo_q[4:0] == 5'h1F && !i_sfr_wr
    |=> t0_lo_q[4:0] == 5'h00 &&
        t0_hi_q == $past(t0_hi_q) + 8'h01)
    else $error("13-bit carry into high byte wrong");
  a_ovf_flag: assert property (@(posedge i_clk) // R02
    disable iff (!i_arst_n)
    i_ce && set0 |=> flag0_q && o_irq_t0)
    else $error("overflow did not set flag 0");
  a_reload_copy: assert property (@(posedge i_clk) // R08
    disable iff (!i_arst_n)
    i_ce && mode0 == dtc_pkg::DTC_MODE_RELOAD && set0 && !i_sfr_wr
    |=> t0_lo_q == $past(t0_hi_q) && $stable(t0_hi_q))
    else $error("autoreload did not copy high byte");
  a_t1_split_hold: assert property (@(posedge i_clk) // R10
    disable iff (!i_arst_n)
    i_ce && mode1 == dtc_pkg::DTC_MODE_SPLIT && !i_sfr_wr
    |=> $stable({t1_hi_q, t1_lo_q}))
    else $error("timer 1 moved in split mode");
  a_split_high: assert property (@(posedge i_clk) // R12
    disable iff (!i_arst_n)
    i_ce && split0 && run1_q && t0_hi_q == 8'hFF
    |=> flag1_q ##1 1'b1)
    else $error("split high byte did not set flag 1");
  a_vector_clear: assert property (@(posedge i_clk) // R16
    disable iff (!i_arst_n)
    i_ce && i_vector_t0 && !set0 && !i_sfr_wr |=> !flag0_q)
    else $error("vector did not clear flag 0");
  a_set_wins: assert property (@(posedge i_clk) // R02
    disable iff (!i_arst_n)
    i_ce && i_vector_t1 && set1 |=> flag1_q)
    else $error("clear beat a simultaneous overflow");
  a_ce_freeze: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    !i_ce |=> $stable({t0_hi_q, t0_lo_q, t1_hi_q, t1_lo_q, flag0_q}))
    else $error("state moved with clock enable low");

endmodule

/* File: sim/dtc_pin_partner.sv */
// Far-side model of the timer count pins and external interrupt pins
`timescale 1ns/1ps
module dtc_pin_partner (
  // Clock
  input  wire logic       i_clk,
  // Commands from the bench
  input  wire logic [1:0] i_gate,
  input  wire logic       i_go,
  input  wire logic       i_sel,
  input  wire logic [3:0] i_len,
  // Pins toward the timers
  output logic      [1:0] o_count_pin,
  output logic      [1:0] o_irq_pin,
  output logic            o_busy
);
  // ---------------------------------------------------------------
  // Burst sequencer
  // ---------------------------------------------------------------
  logic [5:0] phase_q = 6'h00; // Quarter steps left in the burst
  logic       sel_q   = 1'b0;  // Which count pin is pulsed

  // Four clocks per pulse, well inside the two-clock synchroniser limit
  always @(posedge i_clk) begin
    if (i_go && phase_q == 6'h00) begin
      phase_q <= {i_len, 2'h0};
      sel_q   <= i_sel;
    end else if (phase_q != 6'h00) begin
      phase_q <= phase_q - 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // Pin levels
  // ---------------------------------------------------------------
  // Idle count pins stand high, so only burst pulses give falling edges
  assign o_count_pin[0] = ~(phase_q[1] && !sel_q);
  assign o_count_pin[1] = ~(phase_q[1] && sel_q);
  // Gate pins are held by the far device at the level the bench asks
  assign o_irq_pin      = i_gate;
  assign o_busy         = (phase_q != 6'h00);
endmodule

/* File: sim/dtc_timers_tb.sv */
// Self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
module dtc_timers_tb;
  // ---------------------------------------------------------------
  // Design and partner signals
  // ---------------------------------------------------------------
  logic        clk, arst_n, ce;   // Clock, reset, enable
  logic [7:0]  addr, wdata, rdata; // Register port
  logic        wr;                 // Write strobe
  logic        vec0, vec1;         // Vector acknowledges
  logic [1:0]  cpin, ipin;         // Pins from the partner
  logic        irq0, irq1, baud;   // Requests and baud tick
  logic [1:0]  gate;               // Gate levels asked of partner
  logic        go, sel, busy;      // Burst control
  logic [3:0]  len;                // Pulses per burst
  // ---------------------------------------------------------------
  // Bench state
  // ---------------------------------------------------------------
  logic        mark, mark_q;       // Read launched / result due
  logic [7:0]  exp_q[$];           // Expected read data, oldest first
  string       name_q[$];          // Names of the pending reads
  logic [7:0]  vals[4];            // Bytes written at random
  logic [31:0] lfsr;               // Random source
  int          n_mismatch, comparisons, n_baud, cycles;

  dtc_timers dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_ce(ce),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .i_vector_t0(vec0), .i_vector_t1(vec1),
    .i_count_pin_t0(cpin[0]), .i_count_pin_t1(cpin[1]),
    .i_ext_irq_pin_zero(ipin[0]), .i_ext_irq_pin_one(ipin[1]),
    .o_irq_t0(irq0), .o_irq_t1(irq1), .o_baud_tick_t1(baud)
  );

  dtc_pin_partner u_pins (
    .i_clk(clk), .i_gate(gate), .i_go(go), .i_sel(sel), .i_len(len),
    .o_count_pin(cpin), .o_irq_pin(ipin), .o_busy(busy)
  );

  // ---------------------------------------------------------------
  // Clock, result monitor, timeout
  // ---------------------------------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // Read data lands one edge after the address is driven
  always @(posedge clk) mark_q <= mark;
  always @(negedge clk) begin
    if (mark_q && exp_q.size() > 0)
      chk(name_q.pop_front(), exp_q.pop_front(), rdata);
    if (baud === 1'b1)
      n_baud++;
  end

  // Whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobe is dropped at the sampling edge, so calls are spaced
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input string what, input logic [7:0] a,
                        input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    mark <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(what);
    @(posedge clk);
    mark <= 1'b0;
  endtask

  // Run for n+1 counts; flags checked before the stop write clears them
  task automatic run_for(input logic [7:0] ctl, input int n,
                         input logic [1:0] exp_irq);
    wr_reg(dtc_pkg::ADDR_CTRL, ctl);
    repeat (n - 1) @(posedge clk);
    @(negedge clk);
    chk("irq0", {7'h00, exp_irq[0]}, {7'h00, irq0});
    chk("irq1", {7'h00, exp_irq[1]}, {7'h00, irq1});
    wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
  endtask

  task automatic vector(input int t);
    @(posedge clk);
    if (t == 0) vec0 <= 1'b1;
    else vec1 <= 1'b1;
    @(posedge clk);
    vec0 <= 1'b0;
    vec1 <= 1'b0;
    @(negedge clk);
  endtask

  task automatic note(input string what);
    $display("test %s done", what);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {arst_n, addr, wdata, wr, vec0, vec1, mark} = '0;
    {gate, go, sel, len} = '0;
    {n_mismatch, comparisons} = '0;
    lfsr = 32'hB9DA;
    ce   = 1'b1;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, unmapped 0x8E included
    for (int i = 0; i < 7; i++)
      rd_reg("reset", 8'h88 + i[7:0], 8'h00);
    note("reset");
    // Count bytes, control low bits, unmapped place, mode register
    for (int i = 0; i < 4; i++) begin
      lfsr    = lfsr_next(lfsr);
      vals[i] = lfsr[7:0];
      wr_reg(8'h8A + i[7:0], vals[i]);
      rd_reg("count byte", 8'h8A + i[7:0], vals[i]);
    end
    wr_reg(8'h8E, 8'h55);
    rd_reg("unmapped", 8'h8E, 8'h00);
    wr_reg(dtc_pkg::ADDR_CTRL, 8'h0F);
    rd_reg("ctrl low", dtc_pkg::ADDR_CTRL, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'h8A, 8'h77);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg("frozen", 8'h8A, vals[0]);
    lfsr = lfsr_next(lfsr);
    wr_reg(dtc_pkg::ADDR_MODE, lfsr[7:0]);
    rd_reg("mode", dtc_pkg::ADDR_MODE, lfsr[7:0]);
    note("registers");
    // Flags set by software, cleared by vectoring
    wr_reg(dtc_pkg::ADDR_CTRL, 8'hA0);
    @(negedge clk);
    chk("irq1 set", 8'h01, {7'h00, irq1});
    vector(0);
    chk("irq0 vec", 8'h00, {7'h00, irq0});
    chk("irq1 kept", 8'h01, {7'h00, irq1});
    vector(1);
    chk("irq1 vec", 8'h00, {7'h00, irq1});
    note("flags");
    // 16-bit wrap, one count per clock, bytes kept after stop
    wr_reg(dtc_pkg::ADDR_MODE, 8'h01);
    wr_reg(8'h8C, 8'hFF);
    wr_reg(8'h8A, 8'hFE);
    run_for(8'h10, 5, 2'b01);
    rd_reg("m1 low", 8'h8A, 8'h04);
    rd_reg("m1 high", 8'h8C, 8'h00);
    // 13-bit: upper low bits held, carry from bit 4
    wr_reg(dtc_pkg::ADDR_MODE, 8'h00);
    wr_reg(8'h8C, 8'hFF);
    wr_reg(8'h8A, 8'hFE);
    run_for(8'h10, 3, 2'b01);
    rd_reg("m0 low", 8'h8A, 8'hE2);
    rd_reg("m0 high", 8'h8C, 8'h00);
    note("wide modes");
    // Timer 1 autoreload
    wr_reg(dtc_pkg::ADDR_MODE, 8'h20);
    wr_reg(8'h8D, 8'hF0);
    wr_reg(8'h8B, 8'hFD);
    run_for(8'h40, 6, 2'b10);
    rd_reg("reload low", 8'h8B, 8'hF4);
    rd_reg("reload high", 8'h8D, 8'hF0);
    // Timer 0 autoreload, same preset
    wr_reg(dtc_pkg::ADDR_MODE, 8'h02);
    wr_reg(8'h8C, 8'hF0);
    wr_reg(8'h8A, 8'hFD);
    run_for(8'h10, 6, 2'b01);
    rd_reg("t0 reload low", 8'h8A, 8'hF4);
    rd_reg("t0 reload high", 8'h8C, 8'hF0);
    chk("baud ticks", 8'h01, n_baud[7:0]);
    // Timer 1 held in mode 3, restarted out of it
    wr_reg(dtc_pkg::ADDR_MODE, 8'h30);
    wr_reg(8'h8B, 8'h10);
    run_for(8'h40, 5, 2'b00);
    rd_reg("held", 8'h8B, 8'h10);
    wr_reg(dtc_pkg::ADDR_MODE, 8'h10);
    run_for(8'h40, 4, 2'b00);
    rd_reg("restart", 8'h8B, 8'h15);
    note("timer 1 modes");
    // Timer 0 split into two 8-bit counters
    wr_reg(dtc_pkg::ADDR_MODE, 8'h03);
    wr_reg(8'h8A, 8'hFE);
    wr_reg(8'h8C, 8'hFE);
    run_for(8'h10, 4, 2'b01);
    rd_reg("split low", 8'h8A, 8'h03);
    rd_reg("split high", 8'h8C, 8'hFE);
    wr_reg(8'h8D, 8'hFF);
    wr_reg(8'h8B, 8'h1E);
    run_for(8'h40, 4, 2'b10);
    rd_reg("split low kept", 8'h8A, 8'h03);
    rd_reg("split high run", 8'h8C, 8'h03);
    rd_reg("t1 low", 8'h8B, 8'h03);
    rd_reg("t1 high", 8'h8D, 8'h00);
    chk("baud ticks", 8'h02, n_baud[7:0]);
    note("split");
    // Gate qualify: pin low blocks, pin high lets count
    for (int t = 0; t < 2; t++) begin
      wr_reg(dtc_pkg::ADDR_MODE, (t == 0) ? 8'h09 : 8'h90);
      wr_reg(8'h8A + t[7:0], 8'h00);
      wr_reg(8'h8C + t[7:0], 8'h00);
      gate <= 2'h0;
      repeat (4) @(posedge clk);
      run_for((t == 0) ? 8'h10 : 8'h40, 6, 2'b00);
      rd_reg("gate low", 8'h8A + t[7:0], 8'h00);
      gate <= 2'h3;
      repeat (4) @(posedge clk);
      run_for((t == 0) ? 8'h10 : 8'h40, 6, 2'b00);
      rd_reg("gate high", 8'h8A + t[7:0], 8'h07);
      gate <= 2'h0;
    end
    note("gate");
    // Counter function on pin falling edges
    for (int t = 0; t < 2; t++) begin
      wr_reg(dtc_pkg::ADDR_MODE, (t == 0) ? 8'h05 : 8'h50);
      wr_reg(8'h8A + t[7:0], 8'h00);
      wr_reg(8'h8C + t[7:0], 8'h00);
      wr_reg(dtc_pkg::ADDR_CTRL, (t == 0) ? 8'h10 : 8'h40);
      @(posedge clk);
      go  <= 1'b1;
      sel <= t[0];
      len <= 4'h5 + t[3:0];
      @(posedge clk);
      go  <= 1'b0;
      // Burst starts at this edge; look at busy once it has settled
      @(negedge clk);
      for (int w = 0; w < 200 && busy !== 1'b0; w++)
        @(negedge clk);
      repeat (6) @(posedge clk);
      wr_reg(dtc_pkg::ADDR_CTRL, 8'h00);
      rd_reg("pin count", 8'h8A + t[7:0], 8'h05 + t[7:0]);
    end
    note("counter");
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
